//--- design/rgc_global_command.sv
/*
 global command register of the remapping unit with its status flags,
 pointer registers and transaction-boundary switch.
 assumes a classic wishbone master on mclk, and a dma datapath that
 reports transactions in flight and can be told to hold new ones.
*/
`timescale 1ns/1ns
`default_nettype none
module rgc_global_command
    import rgc_pkg::*;
#(
    parameter bit DRAIN_SUPPORT = 1'b1,
    parameter bit FLOG_SUPPORT = 1'b1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dmaInFlight,
    input wire logic dmaTxnStart,
    output logic dmaHold,
    output logic remapOn,
    output logic [63:0] activeRootPtr,
    output logic [63:0] activeFaultLogPtr
);
    logic ackQ;
    logic wrStb;
    logic cmdWr;
    logic remapReqQ;
    logic remapActiveFlagQ;
    logic rootLoadedFlagQ;
    logic flogLoadedFlagQ;
    logic [63:0] rootAddrQ;
    logic [63:0] flogAddrQ;
    logic [63:0] activeRootQ;
    logic [63:0] activeFlogQ;
    logic remapOnQ;
    logic [2:0] startVec;
    logic [2:0] busyVec;
    logic [2:0] doneVec;
    logic anyBusy;
    logic quietNow;
    logic [31:0] rdData;

    assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && !ackQ;
    assign cmdWr = wrStb && (wb_adr_i == RGC_CMD_OFS) && wb_sel_i[3];
    assign anyBusy = |busyVec;

    // bus answers one cycle after the request, drops the next cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= wb_cyc_i && wb_stb_i && !ackQ;
        end
    end
    assign wb_ack_o = ackQ;

    // commands arrive only while nothing is busy; one field per write expected
    always_comb begin
        startVec = 3'b000;
        if (cmdWr && !anyBusy) begin
            if (wb_dat_i[RGC_BIT_REMAP] != remapReqQ) begin
                startVec[RGC_OP_REMAP] = 1'b1;
            end
            startVec[RGC_OP_ROOT] = wb_dat_i[RGC_BIT_ROOT];
            startVec[RGC_OP_FLOG] = wb_dat_i[RGC_BIT_FLOG] && FLOG_SUPPORT;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            remapReqQ <= 1'b0;
        end else if (startVec[RGC_OP_REMAP]) begin
            remapReqQ <= wb_dat_i[RGC_BIT_REMAP];
        end
    end

    // source registers for the pointer loads
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rootAddrQ <= 64'h0;
            flogAddrQ <= 64'h0;
        end else if (wrStb) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    unique case (wb_adr_i)
                        RGC_RTA_LO_OFS: rootAddrQ[8*b +: 8] <= wb_dat_i[8*b +: 8];
                        RGC_RTA_HI_OFS: rootAddrQ[32+8*b +: 8] <= wb_dat_i[8*b +: 8];
                        RGC_FLA_LO_OFS: flogAddrQ[8*b +: 8] <= wb_dat_i[8*b +: 8];
                        RGC_FLA_HI_OFS: flogAddrQ[32+8*b +: 8] <= wb_dat_i[8*b +: 8];
                        default: ;
                    endcase
                end
            end
        end
    end

    // hold new dma traffic while any operation waits for a boundary
    assign dmaHold = anyBusy;
    assign quietNow = DRAIN_SUPPORT ? !dmaInFlight : !dmaTxnStart;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gOp
            rgc_one_shot #(
                .STEP_CYC(RGC_STEP_CYC)
            ) uOp (
                .mclk(mclk),
                .reset_n(reset_n),
                .start(startVec[g]),
                .quiet(quietNow),
                .busy(busyVec[g]),
                .done(doneVec[g])
            );
        end
    endgenerate

    // remapping state changes only at completion, between transactions
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            remapOnQ <= 1'b0;
            remapActiveFlagQ <= 1'b0;
        end else if (doneVec[RGC_OP_REMAP]) begin
            remapOnQ <= remapReqQ;
            remapActiveFlagQ <= remapReqQ;
        end
    end

    // pointer adoption and loaded flags; flag clears when a new load starts
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            activeRootQ <= 64'h0;
            rootLoadedFlagQ <= 1'b0;
        end else if (doneVec[RGC_OP_ROOT]) begin
            activeRootQ <= rootAddrQ;
            rootLoadedFlagQ <= 1'b1;
        end else if (startVec[RGC_OP_ROOT]) begin
            rootLoadedFlagQ <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            activeFlogQ <= 64'h0;
            flogLoadedFlagQ <= 1'b0;
        end else if (doneVec[RGC_OP_FLOG]) begin
            activeFlogQ <= flogAddrQ;
            flogLoadedFlagQ <= 1'b1;
        end else if (startVec[RGC_OP_FLOG]) begin
            flogLoadedFlagQ <= 1'b0;
        end
    end

    assign remapOn = remapOnQ;
    assign activeRootPtr = activeRootQ;
    assign activeFaultLogPtr = activeFlogQ;

    // read mux; command register reads zero
    always_comb begin
        rdData = 32'h0;
        unique case (wb_adr_i)
            RGC_CMD_OFS: rdData = 32'h0;
            RGC_STS_OFS: begin
                rdData[RGC_BIT_REMAP] = remapActiveFlagQ;
                rdData[RGC_BIT_ROOT] = rootLoadedFlagQ;
                rdData[RGC_BIT_FLOG] = flogLoadedFlagQ;
            end
            RGC_RTA_LO_OFS: rdData = rootAddrQ[31:0];
            RGC_RTA_HI_OFS: rdData = rootAddrQ[63:32];
            RGC_FLA_LO_OFS: rdData = flogAddrQ[31:0];
            RGC_FLA_HI_OFS: rdData = flogAddrQ[63:32];
            RGC_ACT_LO_OFS: rdData = activeRootQ[31:0];
            RGC_ACT_HI_OFS: rdData = activeRootQ[63:32];
            RGC_AFL_LO_OFS: rdData = activeFlogQ[31:0];
            RGC_AFL_HI_OFS: rdData = activeFlogQ[63:32];
            default: rdData = 32'h0;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0;
        end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ackQ) begin
            wb_dat_o <= rdData;
        end
    end

    property p_remap_switch_at_done;
        @(posedge mclk) disable iff (!reset_n)
        $changed(remapOnQ) |-> $past(doneVec[RGC_OP_REMAP]);
    endproperty
    a_remap_switch_at_done: assert property (p_remap_switch_at_done) else $error("remap changed off completion");

    property p_flag_tracks_on;
        @(posedge mclk) disable iff (!reset_n)
        doneVec[RGC_OP_REMAP] |=> $changed(remapActiveFlagQ) && (remapActiveFlagQ == remapOnQ);
    endproperty
    a_flag_tracks_on: assert property (p_flag_tracks_on) else $error("active flag differs from state");

    property p_remap_value;
        @(posedge mclk) disable iff (!reset_n)
        startVec[RGC_OP_REMAP] |-> (remapOnQ != wb_dat_i[RGC_BIT_REMAP]) ##[1:1000] $changed(remapOnQ);
    endproperty
    a_remap_value: assert property (p_remap_value) else $error("remap not set to request");

    property p_drain;
        @(posedge mclk) disable iff (!reset_n)
        (DRAIN_SUPPORT && doneVec[RGC_OP_REMAP]) |-> !$past(dmaInFlight, 1 + RGC_STEP_CYC);
    endproperty
    a_drain: assert property (p_drain) else $error("remap done without drain");

    property p_cmd_read_zero;
        @(posedge mclk) disable iff (!reset_n)
        (wb_cyc_i && wb_stb_i && !wb_we_i && !ackQ && wb_adr_i == RGC_CMD_OFS) |=> wb_dat_o == 32'h0;
    endproperty
    a_cmd_read_zero: assert property (p_cmd_read_zero) else $error("command read not zero");

    property p_zero_no_action;
        @(posedge mclk) disable iff (!reset_n)
        (cmdWr && !wb_dat_i[RGC_BIT_ROOT]) |-> !startVec[RGC_OP_ROOT];
    endproperty
    a_zero_no_action: assert property (p_zero_no_action) else $error("zero write started load");

    property p_root_adopt;
        @(posedge mclk) disable iff (!reset_n)
        doneVec[RGC_OP_ROOT] |=> (activeRootQ == $past(rootAddrQ)) && rootLoadedFlagQ;
    endproperty
    a_root_adopt: assert property (p_root_adopt) else $error("root pointer not adopted");

    property p_root_flag;
        @(posedge mclk) disable iff (!reset_n)
        $rose(rootLoadedFlagQ) |-> $past(doneVec[RGC_OP_ROOT]);
    endproperty
    a_root_flag: assert property (p_root_flag) else $error("root flag set early");

    property p_flog_adopt;
        @(posedge mclk) disable iff (!reset_n)
        doneVec[RGC_OP_FLOG] |=> (activeFlogQ == $past(flogAddrQ)) && flogLoadedFlagQ;
    endproperty
    a_flog_adopt: assert property (p_flog_adopt) else $error("fault log pointer not adopted");

    property p_flog_flag;
        @(posedge mclk) disable iff (!reset_n)
        $rose(flogLoadedFlagQ) |-> $past(doneVec[RGC_OP_FLOG]);
    endproperty
    a_flog_flag: assert property (p_flog_flag) else $error("fault log flag set early");

    property p_flog_while_on;
        @(posedge mclk) disable iff (!reset_n)
        (startVec[RGC_OP_FLOG] && remapOnQ) |-> ##[1:1000] doneVec[RGC_OP_FLOG];
    endproperty
    a_flog_while_on: assert property (p_flog_while_on) else $error("fault log reload refused");

    property p_flag_clears_on_start;
        @(posedge mclk) disable iff (!reset_n)
        startVec[RGC_OP_ROOT] |=> !rootLoadedFlagQ;
    endproperty
    a_flag_clears_on_start: assert property (p_flag_clears_on_start) else $error("flag not cleared");

    property p_hold_while_busy;
        @(posedge mclk) disable iff (!reset_n)
        (|startVec) |=> dmaHold;
    endproperty
    a_hold_while_busy: assert property (p_hold_while_busy) else $error("new traffic not held");

    property p_remap_start;
        @(posedge mclk) disable iff (!reset_n)
        (cmdWr && !anyBusy && (wb_dat_i[RGC_BIT_REMAP] != remapOnQ)) |-> startVec[RGC_OP_REMAP];
    endproperty
    a_remap_start: assert property (p_remap_start) else $error("remap request not started");

    property p_flog_zero_no_action;
        @(posedge mclk) disable iff (!reset_n)
        (cmdWr && !wb_dat_i[RGC_BIT_FLOG]) |-> !startVec[RGC_OP_FLOG];
    endproperty
    a_flog_zero_no_action: assert property (p_flog_zero_no_action) else $error("zero write started log load");

    property p_flog_flag_clears;
        @(posedge mclk) disable iff (!reset_n)
        startVec[RGC_OP_FLOG] |=> !flogLoadedFlagQ;
    endproperty
    a_flog_flag_clears: assert property (p_flog_flag_clears) else $error("log flag not cleared");

    property p_root_flag_holds;
        @(posedge mclk) disable iff (!reset_n)
        (rootLoadedFlagQ && !startVec[RGC_OP_ROOT]) |=> rootLoadedFlagQ;
    endproperty
    a_root_flag_holds: assert property (p_root_flag_holds) else $error("root flag lost");
endmodule : rgc_global_command
`default_nettype wire

//--- design/rgc_pkg.sv
/*
 constants for the remapping global command register block.
 assumes a classic wishbone slave with 32-bit data and byte addresses.
*/
package rgc_pkg;
    localparam logic [7:0] RGC_CMD_OFS = 8'h18;
    localparam logic [7:0] RGC_STS_OFS = 8'h1c;
    localparam logic [7:0] RGC_RTA_LO_OFS = 8'h20;
    localparam logic [7:0] RGC_RTA_HI_OFS = 8'h24;
    localparam logic [7:0] RGC_FLA_LO_OFS = 8'h28;
    localparam logic [7:0] RGC_FLA_HI_OFS = 8'h2c;
    localparam logic [7:0] RGC_ACT_LO_OFS = 8'h30;
    localparam logic [7:0] RGC_ACT_HI_OFS = 8'h34;
    localparam logic [7:0] RGC_AFL_LO_OFS = 8'h38;
    localparam logic [7:0] RGC_AFL_HI_OFS = 8'h3c;
    localparam int RGC_BIT_REMAP = 31;
    localparam int RGC_BIT_ROOT = 30;
    localparam int RGC_BIT_FLOG = 29;
    localparam int RGC_STEP_CYC = 4;
    typedef enum logic [1:0] {
        RGC_OP_REMAP,
        RGC_OP_ROOT,
        RGC_OP_FLOG
    } rgc_op_t;
endpackage : rgc_pkg

//--- design/rgc_one_shot.sv
/*
 one-shot operation sequencer: takes a start pulse, waits for the
 datapath to be quiet, holds for a fixed settle, then pulses done.
 assumes quiet comes from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module rgc_one_shot
    import rgc_pkg::*;
#(
    parameter int STEP_CYC = RGC_STEP_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic quiet,
    output logic busy,
    output logic done
);
    typedef enum logic [1:0] {
        RGC_S_IDLE,
        RGC_S_WAIT,
        RGC_S_SETTLE
    } rgc_sq_t;
    rgc_sq_t state_q;
    logic [7:0] count_q;

    // waits for quiet, then settles; done pulses once
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= RGC_S_IDLE;
            count_q <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                RGC_S_IDLE: begin
                    if (start) begin
                        state_q <= RGC_S_WAIT;
                    end
                end
                RGC_S_WAIT: begin
                    count_q <= 8'h00;
                    if (quiet) begin
                        state_q <= RGC_S_SETTLE;
                    end
                end
                RGC_S_SETTLE: begin
                    count_q <= count_q + 8'h01;
                    if (count_q == 8'(STEP_CYC - 1)) begin
                        state_q <= RGC_S_IDLE;
                        done <= 1'b1;
                    end
                end
            endcase
        end
    end

    // the done cycle counts as busy so a new start never meets a finishing one
    assign busy = (state_q != RGC_S_IDLE) || done;
endmodule : rgc_one_shot
`default_nettype wire

//--- testbench/rgc_global_command_tb.sv
/*
 self-checking bench for the remapping global command register block.
 assumes rgc_pkg and rgc_global_command are compiled before this file.
*/
`timescale 1ns/1ns
`default_nettype none
module rgc_global_command_tb
    import rgc_pkg::*;
;
    logic mclk = 1'b0;
    logic resetN = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    logic dmaInFlight = 1'b0;
    logic dmaTxnStart = 1'b0;
    logic dmaHold;
    logic remapOn;
    logic [63:0] activeRootPtr;
    logic [63:0] activeFaultLogPtr;
    logic [31:0] rd;
    logic [63:0] rdPair;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    always #4 mclk = ~mclk;

    rgc_global_command i_dut (
        .mclk(mclk),
        .reset_n(resetN),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_we_i(wbWe),
        .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel),
        .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck),
        .dmaInFlight(dmaInFlight),
        .dmaTxnStart(dmaTxnStart),
        .dmaHold(dmaHold),
        .remapOn(remapOn),
        .activeRootPtr(activeRootPtr),
        .activeFaultLogPtr(activeFaultLogPtr)
    );

    task automatic results();
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle: request held until ack is sampled, then released
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hf;
        wbDatW <= dat;
        do begin
            @(posedge mclk);
        end while (wbAck !== 1'b1);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat);
    endtask : wr

    task automatic rdw(input logic [7:0] adr);
        wb_xfer(1'b0, adr, 32'h0);
    endtask : rdw

    task automatic rd_pair(input logic [7:0] adr);
        rdw(adr);
        rdPair[31:0] = rd;
        rdw(adr + 8'h04);
        rdPair[63:32] = rd;
    endtask : rd_pair

    // polls status until the flag reaches the wanted level, bounded
    task automatic wait_flag(input int idx, input logic val);
        int n;
        n = 0;
        do begin
            rdw(RGC_STS_OFS);
            n++;
        end while (rd[idx] !== val && n < 40);
    endtask : wait_flag

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge mclk);
        resetN <= 1'b1;
        rdw(RGC_STS_OFS);
        chk(rd, 64'h0);
        chk(remapOn, 64'h0);
        // root load held off by traffic in flight
        wr(RGC_RTA_LO_OFS, 32'h89ab_c000);
        wr(RGC_RTA_HI_OFS, 32'h0000_0012);
        dmaInFlight <= 1'b1;
        wr(RGC_CMD_OFS, 32'h4000_0000);
        repeat (10) @(posedge mclk);
        chk(dmaHold, 64'h1);
        rdw(RGC_STS_OFS);
        chk(rd[RGC_BIT_ROOT], 64'h0);
        chk(activeRootPtr, 64'h0);
        dmaInFlight <= 1'b0;
        wait_flag(RGC_BIT_ROOT, 1'b1);
        chk(rd[RGC_BIT_ROOT], 64'h1);
        chk(activeRootPtr, 64'h12_89ab_c000);
        chk(dmaHold, 64'h0);
        rd_pair(RGC_ACT_LO_OFS);
        chk(rdPair, 64'h12_89ab_c000);
        // zero write leaves pointer and flags alone
        wr(RGC_RTA_LO_OFS, 32'h5555_5000);
        wr(RGC_CMD_OFS, 32'h0);
        repeat (10) @(posedge mclk);
        chk(activeRootPtr, 64'h12_89ab_c000);
        rdw(RGC_STS_OFS);
        chk(rd, 64'h4000_0000);
        // enable switches only once the datapath is quiet
        dmaInFlight <= 1'b1;
        wr(RGC_CMD_OFS, 32'h8000_0000);
        repeat (10) @(posedge mclk);
        chk(remapOn, 64'h0);
        chk(dmaHold, 64'h1);
        dmaInFlight <= 1'b0;
        wait_flag(RGC_BIT_REMAP, 1'b1);
        chk(rd[RGC_BIT_REMAP], 64'h1);
        chk(remapOn, 64'h1);
        // first fault log load while remapping is active
        wr(RGC_FLA_LO_OFS, 32'h0abc_d000);
        wr(RGC_FLA_HI_OFS, 32'h0000_0034);
        wr(RGC_CMD_OFS, 32'ha000_0000);
        wait_flag(RGC_BIT_FLOG, 1'b1);
        chk(rd[RGC_BIT_FLOG], 64'h1);
        chk(rd[RGC_BIT_REMAP], 64'h1);
        chk(activeFaultLogPtr, 64'h34_0abc_d000);
        rd_pair(RGC_AFL_LO_OFS);
        chk(rdPair, 64'h34_0abc_d000);
        chk(remapOn, 64'h1);
        // same root pointer reloaded while remapping stays active
        wr(RGC_RTA_LO_OFS, 32'h89ab_c000);
        wr(RGC_CMD_OFS, 32'hc000_0000);
        wait_flag(RGC_BIT_ROOT, 1'b1);
        chk(rd[RGC_BIT_ROOT], 64'h1);
        chk(remapOn, 64'h1);
        chk(activeRootPtr, 64'h12_89ab_c000);
        rdw(RGC_CMD_OFS);
        chk(rd, 64'h0);
        rdw(8'hf0);
        chk(rd, 64'h0);
        // disable, load flags untouched
        wr(RGC_CMD_OFS, 32'h0);
        wait_flag(RGC_BIT_REMAP, 1'b0);
        chk(rd, 64'h6000_0000);
        chk(remapOn, 64'h0);
        chk(activeRootPtr, 64'h12_89ab_c000);
        // reset in mid-run clears state and flags
        resetN <= 1'b0;
        @(posedge mclk);
        resetN <= 1'b1;
        rdw(RGC_STS_OFS);
        chk(rd, 64'h0);
        chk(activeRootPtr, 64'h0);
        chk(activeFaultLogPtr, 64'h0);
        results();
    end
endmodule : rgc_global_command_tb
`default_nettype wire
